// ---- hdl/nfh_pkg.sv ----
// Constants shared by the NAND flash host controller
package nfh_pkg;
   // Opcodes
   localparam logic [7:0] CMD_READ1 = 8'h00;
   localparam logic [7:0] CMD_READ2 = 8'h30;
   localparam logic [7:0] CMD_PROG1 = 8'h80;
   localparam logic [7:0] CMD_PROG2 = 8'h10;
   localparam logic [7:0] CMD_ERASE1 = 8'h60;
   localparam logic [7:0] CMD_ERASE2 = 8'hD0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   // Organisation
   localparam int PAGE_BYTES = 2112;
   localparam int PAGES_PER_BLOCK = 64;
   localparam int BLOCKS = 1024;
   localparam int ECC_SPAN_BYTES = 528;
   localparam int ECC_BITS = 4;
   // Timing: strobe phase length in clocks
   localparam int CLK_HZ = 20000000;
   localparam int STROBE_NS = 25;
   localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int BUSY_MAX_US = 25;
   localparam int BUSY_MAX_CYC = BUSY_MAX_US * (CLK_HZ / 1000000);
   // Host operations
   typedef enum logic [2:0] {
      NFH_OP_READ,
      NFH_OP_PROG,
      NFH_OP_ERASE,
      NFH_OP_STATUS,
      NFH_OP_RESET
   } nfh_op_t;
endpackage : nfh_pkg

// ---- hdl/nfh_fifo.sv ----
// Synchronous valid/ready FIFO for host data path
`timescale 1ns/1ps
`default_nettype none
module nfh_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   // Storage array
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic doWr;
   logic doRd;
   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;
   // Write data
   always_ff @(posedge clk) begin
      if (doWr) begin
         mem[wrPtr] <= inData;
      end
   end
   // Pointers and occupancy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWr) begin
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         end
         if (doRd) begin
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         end
         count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
      end
   end
endmodule : nfh_fifo
`default_nettype wire

// ---- hdl/nfh_host.sv ----
// NAND flash host controller driving the device strobes
`timescale 1ns/1ps
`default_nettype none
module nfh_host #(
   parameter int FIFO_DEPTH = 16,
   parameter int BUSY_LIMIT = nfh_pkg::BUSY_MAX_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Operation request
   input wire logic opValid,
   output logic opReady,
   input wire nfh_pkg::nfh_op_t opCode,
   input wire logic [11:0] opColumn,
   input wire logic [15:0] opRow,
   input wire logic [11:0] opLength,
   input wire logic lockEnable,
   input wire logic writeAllow,
   // Write data stream
   input wire logic wrValid,
   output logic wrReady,
   input wire logic [7:0] wrData,
   // Read data stream
   output logic rdValid,
   input wire logic rdReady,
   output logic [7:0] rdData,
   // Completion
   output logic opDone,
   output logic busyTimeout,
   // Flash pins
   output logic chipSel_n,
   output logic cmdLatch,
   output logic addrLatch,
   output logic writeStrobe_n,
   output logic read_strobe_n,
   output logic writeProt_n,
   output logic lockStrap,
   input wire logic [7:0] ioLinesIn,
   output logic [7:0] ioLinesOut,
   output logic ioLinesOe,
   input wire logic readyBusy
);
   typedef enum logic [3:0] {
      S_IDLE, S_CMD1, S_ADDR, S_DATAW, S_CMD2, S_WAITRB, S_DATAR, S_DONE
   } nfh_state_t;
   localparam logic [3:0] PH_CYC = 4'(nfh_pkg::STROBE_CYC);
   nfh_state_t state;
   // Latched request
   nfh_pkg::nfh_op_t op;
   logic [11:0] column;
   logic [15:0] row;
   logic [11:0] remain;
   logic [2:0] addrIdx;
   logic [2:0] addrCnt;
   // Strobe phase timer: phase 0 low, phase 1 high
   logic [3:0] phCnt;
   logic phase;
   logic phEnd;
   logic phDone; // Current phase over, read low phase stretched
   logic [15:0] busyCnt;
   // Ready/busy and io line synchronisers
   logic rbMeta;
   logic rbSync;
   logic [7:0] ioMeta;
   logic [7:0] ioSync;
   // Read FIFO fill side, write FIFO drain side
   logic rfValid;
   logic rfReady;
   logic [7:0] rfData;
   logic wfValid;
   logic [7:0] wfData;
   logic wfReady;
   assign phEnd = (phCnt == PH_CYC - 4'h1);
   // Read strobe stays low until the byte has crossed both io flops
   assign phDone = (state == S_DATAR && !phase) ?
                   (phCnt == PH_CYC + 4'h2) : phEnd;
   assign opReady = (state == S_IDLE);
   assign lockStrap = lockEnable;
   assign writeProt_n = writeAllow;
   // Pin synchronisers
   always_ff @(posedge clk) begin
      rbMeta <= readyBusy;
      rbSync <= rbMeta;
      ioMeta <= ioLinesIn;
      ioSync <= ioMeta;
   end
   // Write data FIFO towards the flash
   nfh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) wrFifo (
      .clk(clk), .rst_n(rst_n),
      .inValid(wrValid), .inReady(wrReady), .inData(wrData),
      .outValid(wfValid), .outReady(wfReady), .outData(wfData)
   );
   // Read data FIFO towards the user; bytes leave uncorrected, so the
   // reader's 4-bit per 528-byte corrector sits behind rdData
   nfh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rdFifo (
      .clk(clk), .rst_n(rst_n),
      .inValid(rfValid), .inReady(rfReady), .inData(rfData),
      .outValid(rdValid), .outReady(rdReady), .outData(rdData)
   );
   // Data byte leaves write FIFO at end of its strobe high phase
   assign wfReady = (state == S_DATAW) && phase && phEnd;
   // Read byte captured at end of the stretched read strobe low phase
   assign rfValid = (state == S_DATAR) && !phase && phDone;
   assign rfData = ioSync;
   // Strobe phase timer, stalls on empty/full FIFO
   always_ff @(posedge clk) begin
      if (!rst_n || state == S_IDLE || state == S_WAITRB) begin
         phCnt <= '0;
         phase <= 1'b0;
      end else if ((state == S_DATAW && !wfValid) ||
                   (state == S_DATAR && !phase && !rfReady)) begin
         phCnt <= phCnt;
      end else if (phDone) begin
         phCnt <= '0;
         phase <= !phase;
      end else begin
         phCnt <= phCnt + 4'h1;
      end
   end
   // Sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= S_IDLE;
         op <= nfh_pkg::NFH_OP_RESET;
         column <= '0;
         row <= '0;
         remain <= '0;
         addrIdx <= '0;
         addrCnt <= '0;
         opDone <= 1'b0;
         busyTimeout <= 1'b0;
         busyCnt <= '0;
      end else begin
         opDone <= 1'b0;
         unique case (state)
            S_IDLE: begin
               busyTimeout <= busyTimeout && !opValid;
               if (opValid) begin
                  op <= opCode;
                  column <= opColumn;
                  row <= opRow;
                  remain <= opLength;
                  state <= S_CMD1;
               end
            end
            S_CMD1: begin
               if (phase && phEnd) begin
                  addrIdx <= '0;
                  // Fresh busy count, reset goes straight to the wait
                  busyCnt <= '0;
                  // Erase takes only the two row cycles
                  addrCnt <= (op == nfh_pkg::NFH_OP_ERASE) ? 3'd2 : 3'd4;
                  if (op == nfh_pkg::NFH_OP_RESET) begin
                     state <= S_WAITRB;
                  end else if (op == nfh_pkg::NFH_OP_STATUS) begin
                     remain <= 12'h001;
                     state <= S_DATAR;
                  end else begin
                     state <= S_ADDR;
                  end
               end
            end
            S_ADDR: begin
               if (phase && phEnd) begin
                  addrIdx <= addrIdx + 3'd1;
                  if (addrIdx + 3'd1 == addrCnt) begin
                     state <= (op == nfh_pkg::NFH_OP_PROG) ? S_DATAW
                                                          : S_CMD2;
                  end
               end
            end
            S_DATAW: begin
               if (wfReady) begin
                  remain <= remain - 12'h001;
                  if (remain == 12'h001) begin
                     state <= S_CMD2;
                  end
               end
            end
            S_CMD2: begin
               if (phase && phEnd) begin
                  busyCnt <= '0;
                  state <= S_WAITRB;
               end
            end
            S_WAITRB: begin
               // Wait for ready high once five clocks have passed; only reads time out
               busyCnt <= busyCnt + 16'h0001;
               if (op == nfh_pkg::NFH_OP_READ &&
                   busyCnt >= 16'(BUSY_LIMIT)) begin
                  busyTimeout <= 1'b1;
                  state <= S_DONE;
               end else if (busyCnt > 16'h0004 && rbSync) begin
                  state <= (op == nfh_pkg::NFH_OP_READ) ? S_DATAR : S_DONE;
               end
            end
            S_DATAR: begin
               // Count only bytes the FIFO really took
               if (rfValid && rfReady) begin
                  remain <= remain - 12'h001;
                  if (remain == 12'h001) begin
                     state <= S_DONE;
                  end
               end
            end
            S_DONE: begin
               opDone <= 1'b1;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
   // Pin drive: selects, strobes and bus from registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chipSel_n <= 1'b1;
         cmdLatch <= 1'b0;
         addrLatch <= 1'b0;
         writeStrobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
         ioLinesOut <= 8'h00;
         ioLinesOe <= 1'b0;
      end else begin
         // Chip select held low through whole operation
         chipSel_n <= (state == S_IDLE) || (state == S_DONE);
         cmdLatch <= (state == S_CMD1) || (state == S_CMD2);
         addrLatch <= (state == S_ADDR);
         writeStrobe_n <= !(((state == S_CMD1) || (state == S_CMD2) ||
                            (state == S_ADDR) ||
                            (state == S_DATAW && wfValid)) && !phase);
         read_strobe_n <= !(state == S_DATAR && !phase);
         ioLinesOe <= (state == S_CMD1) || (state == S_CMD2) ||
                      (state == S_ADDR) || (state == S_DATAW);
         unique case (state)
            S_CMD1: begin
               unique case (op)
                  nfh_pkg::NFH_OP_READ: ioLinesOut <= nfh_pkg::CMD_READ1;
                  nfh_pkg::NFH_OP_PROG: ioLinesOut <= nfh_pkg::CMD_PROG1;
                  nfh_pkg::NFH_OP_ERASE: ioLinesOut <= nfh_pkg::CMD_ERASE1;
                  nfh_pkg::NFH_OP_STATUS: ioLinesOut <= nfh_pkg::CMD_STATUS;
                  default: ioLinesOut <= nfh_pkg::CMD_RESET;
               endcase
            end
            S_CMD2: begin
               unique case (op)
                  nfh_pkg::NFH_OP_READ: ioLinesOut <= nfh_pkg::CMD_READ2;
                  nfh_pkg::NFH_OP_PROG: ioLinesOut <= nfh_pkg::CMD_PROG2;
                  default: ioLinesOut <= nfh_pkg::CMD_ERASE2;
               endcase
            end
            S_ADDR: begin
               // Column low, column high (upper nibble low), rows
               unique case (addrIdx + ((op == nfh_pkg::NFH_OP_ERASE) ?
                                       3'd2 : 3'd0))
                  3'd0: ioLinesOut <= column[7:0];
                  3'd1: ioLinesOut <= {4'h0, column[11:8]};
                  3'd2: ioLinesOut <= row[7:0];
                  default: ioLinesOut <= row[15:8];
               endcase
            end
            S_DATAW: ioLinesOut <= wfData;
            default: ioLinesOut <= ioLinesOut;
         endcase
      end
   end
endmodule : nfh_host
`default_nettype wire

// ---- bench/nfh_flash_model.sv ----
// Behavioural NAND flash device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model #(
   parameter int T_RD = 1000,
   parameter int T_PG = 2000
) (
   // Host strobes
   input wire logic chipSel_n,
   input wire logic cmdLatch,
   input wire logic addrLatch,
   input wire logic writeStrobe_n,
   input wire logic read_strobe_n,
   input wire logic writeProt_n,
   input wire logic slow,
   // Shared bus and busy pull-down
   input wire logic [7:0] io,
   output logic [7:0] ioOut,
   output logic busyLow
);
   logic [7:0] mem [int], pb [int], adr [4]; // Array, page register
   logic [7:0] cmd, dout;
   logic [15:0] row;
   logic [11:0] col;
   int na;
   initial busyLow = 1'b0;
   initial dout = 8'hFF; // Blank page 0 loaded at power-up
   // Busy window; chip select going high does not cut it short
   task automatic hold(input int t);
      fork
         begin
            busyLow = 1'b1;
            #(t) busyLow = 1'b0;
         end
      join_none
   endtask : hold
   // Latch on the rising write strobe while selected
   always @(posedge writeStrobe_n) begin
      if (!chipSel_n && cmdLatch) begin
         cmd = io;
         na = 0;
         case (io)
            8'h80: pb.delete();
            8'h30: hold(slow ? 4 * T_RD : T_RD);
            8'h10: begin
               if (writeProt_n) foreach (pb[c]) mem[{row, c[11:0]}] = pb[c];
               hold(T_PG);
            end
            8'hD0: begin
               if (writeProt_n) foreach (mem[k])
                  if (k[27:18] == {adr[1], adr[0][7:6]}) mem[k] = 8'hFF;
               hold(T_PG);
            end
            8'h70: dout = {writeProt_n, 7'h40};
            8'hFF: hold(500);
            8'h15: begin // Commit page, register free for new bytes
               if (writeProt_n) foreach (pb[c]) mem[{row, c[11:0]}] = pb[c];
               pb.delete();
               hold(T_RD);
            end
            8'h85: na = 0; // Copy-back keeps the page register
            8'h31: begin // Next page streams while it is fetched
               row++;
               col = '0;
               hold(T_RD / 4);
            end
            default: ;
         endcase
      end else if (!chipSel_n && addrLatch) begin
         if (na < 4) adr[na] = io;
         na++;
         col = {adr[1][3:0], adr[0]};
         row = {adr[3], adr[2]};
      end else if (!chipSel_n) begin
         pb[col] = io;
         col++;
      end
   end
   // Each falling read strobe while selected puts out the next byte, unless status was the last command
   always @(negedge read_strobe_n) begin
      if (!chipSel_n && cmd != 8'h70) begin
         dout = mem.exists({row, col}) ? mem[{row, col}] : 8'hFF;
         col++;
      end
   end
   // Deselected bus shows the inverse, never a stale byte
   assign ioOut = chipSel_n ? ~dout : dout;
endmodule : nfh_flash_model
`default_nettype wire

// ---- bench/nfh_host_sva.sv ----
// Pin protocol checker for the NAND flash host controller
`timescale 1ns/1ps
`default_nettype none
module nfh_host_sva (
   // Clock, reset, request
   input wire logic clk,
   input wire logic rst_n,
   input wire logic opValid,
   input wire logic opReady,
   input wire logic opDone,
   input wire logic writeAllow,
   // Flash pins
   input wire logic chipSel_n,
   input wire logic cmdLatch,
   input wire logic addrLatch,
   input wire logic writeStrobe_n,
   input wire logic read_strobe_n,
   input wire logic writeProt_n,
   input wire logic ioLinesOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Write strobe beat: low one clock, then high
   sequence weBeat;
      !writeStrobe_n ##1 writeStrobe_n;
   endsequence
   // First command cycle of an operation
   sequence cmdStart;
      !chipSel_n && cmdLatch && !writeStrobe_n && ioLinesOe;
   endsequence
   oe_needs_cs_a: assert property (ioLinesOe |-> !chipSel_n)
      else $error("io driven while deselected");
   latch_excl_a: assert property (!(cmdLatch && addrLatch))
      else $error("both latch selects high");
   we_pulse_a: assert property ($fell(writeStrobe_n) |-> weBeat)
      else $error("write strobe pulse length wrong");
   we_drive_a: assert property (!writeStrobe_n |-> !chipSel_n && ioLinesOe)
      else $error("write strobe without driven bus");
   re_float_a: assert property (!read_strobe_n |-> !ioLinesOe && !chipSel_n)
      else $error("bus driven during read strobe");
   wp_pass_a: assert property (writeProt_n == writeAllow)
      else $error("write protect not following request");
   done_pulse_a: assert property (opDone |=> !opDone)
      else $error("done longer than one cycle");
   start_cmd_a: assert property (opValid && opReady |-> ##[1:3] cmdStart)
      else $error("no command cycle after request");
endmodule : nfh_host_sva
bind nfh_host nfh_host_sva chk (.clk(clk), .rst_n(rst_n),
   .opValid(opValid), .opReady(opReady), .opDone(opDone),
   .writeAllow(writeAllow), .chipSel_n(chipSel_n), .cmdLatch(cmdLatch),
   .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n),
   .read_strobe_n(read_strobe_n), .writeProt_n(writeProt_n),
   .ioLinesOe(ioLinesOe));
`default_nettype wire

// ---- bench/test_nfh_host.sv ----
// Self-checking bench for the NAND flash host controller
`timescale 1ns/1ps
`default_nettype none
module test_nfh_host;
   logic clk, rst_n, opValid, opReady, lockEnable, writeAllow, slow, stall;
   logic wrValid, wrReady, rdValid, rdReady, opDone, busyTimeout, busyLow;
   logic chipSel_n, cmdLatch, addrLatch, writeStrobe_n, read_strobe_n;
   logic writeProt_n, lockStrap, ioLinesOe;
   logic [7:0] wrData, rdData, ioOut, ioBus, devOut, b;
   logic [11:0] opColumn, opLength, cl;
   logic [15:0] opRow, rw;
   nfh_pkg::nfh_op_t opCode;
   logic [7:0] wq[$], rq[$], eq[$]; // Write, read, expected bytes
   int n_mismatch, compares, seed, i;
   // Bus level: host drives when enabled, otherwise the device
   assign ioBus = ioLinesOe ? ioOut : devOut;
   nfh_host #(.BUSY_LIMIT(50)) dut (.clk(clk), .rst_n(rst_n),
      .opValid(opValid), .opReady(opReady), .opCode(opCode),
      .opColumn(opColumn), .opRow(opRow), .opLength(opLength),
      .lockEnable(lockEnable), .writeAllow(writeAllow),
      .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
      .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
      .opDone(opDone), .busyTimeout(busyTimeout), .chipSel_n(chipSel_n),
      .cmdLatch(cmdLatch), .addrLatch(addrLatch),
      .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
      .writeProt_n(writeProt_n), .lockStrap(lockStrap),
      .ioLinesIn(ioBus), .ioLinesOut(ioOut), .ioLinesOe(ioLinesOe),
      .readyBusy(!busyLow));
   nfh_flash_model dev (.chipSel_n(chipSel_n), .cmdLatch(cmdLatch),
      .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n),
      .read_strobe_n(read_strobe_n), .writeProt_n(writeProt_n),
      .slow(slow), .io(ioBus), .ioOut(devOut), .busyLow(busyLow));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Write feeder and read sink, the sink stalling at random
   always @(posedge clk) begin
      if (wrValid && wrReady) void'(wq.pop_front());
      if (rdValid && rdReady) rq.push_back(rdData);
      wrValid <= wq.size() != 0;
      wrData <= wq.size() != 0 ? wq[0] : 8'h00;
      rdReady <= !stall && 1'($random(seed));
   end
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk8
   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h00, e}, {7'h00, g});
   endtask : chk1
   // Status byte the device gives while ready
   function automatic logic [7:0] stExp(input logic wp);
      return {wp, 7'h40};
   endfunction : stExp
   // One operation: hold the request until taken, then await done
   task automatic doOp(input nfh_pkg::nfh_op_t c, input logic [11:0] a,
                       input logic [15:0] r, input logic [11:0] n);
      int k;
      opCode <= c;
      opColumn <= a;
      opRow <= r;
      opLength <= n;
      opValid <= 1'b1;
      do @(negedge clk); while (opReady !== 1'b1);
      @(posedge clk);
      opValid <= 1'b0;
      for (k = 0; k < 5000 && opDone !== 1'b1; k++) @(negedge clk);
      chk1("opDone", 1'b1, opDone);
      @(posedge clk);
   endtask : doOp
   // Read operation whose bytes are compared with eq
   task automatic readChk(input nfh_pkg::nfh_op_t c, input logic [11:0] a,
                          input logic [15:0] r, input int n);
      int k;
      rq.delete();
      doOp(c, a, r, 12'(n));
      for (k = 0; k < 500 && rq.size() < n; k++) @(posedge clk);
      chk8("rdCount", 8'(n), 8'(rq.size()));
      for (k = 0; k < rq.size(); k++) chk8("rdByte", eq[k], rq[k]);
   endtask : readChk
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   initial begin
      #3000000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      {seed, n_mismatch, compares} = {32'd7594, 32'd0, 32'd0};
      {rst_n, opValid, lockEnable, rdReady, wrValid, slow, stall} = 7'h00;
      {opColumn, opRow, opLength, wrData, writeAllow} = 49'h1;
      opCode = nfh_pkg::NFH_OP_READ;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      lockEnable <= 1'b1;
      for (i = 0; i < 3; i++) begin
         cl = (i == 0) ? 12'd2092 : 12'($unsigned($random(seed)) % 2000);
         rw = 16'($random(seed));
         eq.delete();
         repeat (20) begin
            b = 8'($random(seed));
            eq.push_back(b);
            wq.push_back(b);
         end
         if (i == 0) repeat (40) @(posedge clk);
         if (i == 0) chk1("wrReady", 1'b0, wrReady);
         doOp(nfh_pkg::NFH_OP_PROG, cl, rw, 12'd20);
         stall = (i == 0);
         fork
            begin
               repeat (300) @(posedge clk);
               stall = 1'b0;
            end
         join_none
         readChk(nfh_pkg::NFH_OP_READ, cl, rw, 20);
      end
      eq.delete();
      eq.push_back(stExp(1'b1));
      readChk(nfh_pkg::NFH_OP_STATUS, 12'd0, 16'd0, 1);
      doOp(nfh_pkg::NFH_OP_ERASE, 12'd0, rw, 12'd1);
      eq.delete();
      repeat (20) eq.push_back(8'hFF);
      readChk(nfh_pkg::NFH_OP_READ, cl, rw, 20);
      writeAllow <= 1'b0;
      repeat (20) wq.push_back(8'($random(seed)));
      doOp(nfh_pkg::NFH_OP_PROG, cl, rw, 12'd20);
      writeAllow <= 1'b1;
      readChk(nfh_pkg::NFH_OP_READ, cl, rw, 20);
      chk1("busyTimeout", 1'b0, busyTimeout);
      doOp(nfh_pkg::NFH_OP_RESET, 12'd0, 16'd0, 12'd1);
      slow = 1'b1;
      doOp(nfh_pkg::NFH_OP_READ, cl, rw, 12'd4);
      chk1("busyTimeout", 1'b1, busyTimeout);
      slow = 1'b0;
      repeat (100) @(posedge clk);
      chk1("lockStrap", 1'b1, lockStrap);
      lockEnable <= 1'b0;
      @(negedge clk);
      chk1("lockStrap", 1'b0, lockStrap);
      finish_test();
   end
endmodule : test_nfh_host
`default_nettype wire
